// *** logic/rtcm_defines.svh ***
// Behaviour
// R1: Freeze bit high stops user time updates.
// R2: Freeze bit falling loads user time into counters.
// R3: Calibration off: alarm logic drives shared output.
// R4: Two separately addressable logical slaves on one bus.
// R5: Identity 1010b answers as the memory slave.
// R6: Identity 1101b answers as the clock slave.
// R7: Device is only ever a bus slave.
// R8: Master generates every serial clock pulse.
// R9: Start is data falling while clock high.
// R10: Master opens every transaction with Start.
// R11: Start abandons work, expects fresh address.
// R12: Stop is data rising while clock high.
// R13: Master ends every operation with Stop.
// R14: Stop aborts pending operation, goes idle.
// R15: Master stops only while owning data line.
// R16: Data changes only while clock is low.
// R17: Address bits 3..1 zero, bit 0 direction.
// R18: Ninth bit is acknowledge; missing acknowledge aborts.
// R19: Snapshot rising captures running counters into user.
// R20: Pins synchronised; Start/Stop from successive samples.
`ifndef RTCM_DEFINES_SVH
`define RTCM_DEFINES_SVH

`define RTCM_ID_MEM        4'ha
`define RTCM_ID_CLOCK      4'hd
`define RTCM_ADDR_PAD      3'h0
`define RTCM_BITS_PER_BYTE 4'h8
`define RTCM_FIFO_DEPTH    16
`define RTCM_FIFO_WIDTH    9

`define RTCM_CLK_HZ        100000000
`define RTCM_TICK_MS       1000
`define RTCM_TICK_CYC      ((`RTCM_CLK_HZ / 1000) * `RTCM_TICK_MS)
`define RTCM_CAL_HZ        512
`define RTCM_CAL_HALF_CYC  (`RTCM_CLK_HZ / (2 * `RTCM_CAL_HZ))

`endif

// *** logic/rtcm_fifo.sv ***
`timescale 1ns/10ps
`include "rtcm_defines.svh"
module rtcm_fifo import rtcm_pkg::*; #(
  parameter int WIDTH = `RTCM_FIFO_WIDTH,
  parameter int DEPTH = `RTCM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Fill side
  rtcm_stream_if.snk            in_if,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("rtcm_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;
  wire              empty = (wptr_q == rptr_q);
  wire              full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  wire              do_push = in_if.valid && !full;
  wire              do_pop  = !empty && out_ready;

  assign in_if.ready = !full;
  assign out_valid   = !empty;
  assign out_data    = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_q[wptr_q[AW-1:0]] <= in_if.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (do_push) wptr_q <= wptr_q + 1'b1;
      if (do_pop) rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule

// *** logic/rtcm_front.sv ***
`timescale 1ns/10ps
`include "rtcm_defines.svh"
module rtcm_front import rtcm_pkg::*; #(
  parameter int TICK_CYC     = `RTCM_TICK_CYC,
  parameter int CAL_HALF_CYC = `RTCM_CAL_HALF_CYC,
  parameter int FIFO_DEPTH   = `RTCM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Received byte stream
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_is_clock,
  input  wire logic        rx_ready,
  // Read data source
  input  wire logic [7:0]  rd_data,
  output logic             rd_next,
  output logic             rd_is_clock,
  // Timekeeping control
  input  wire logic        time_set_freeze,
  input  wire logic        time_snapshot,
  input  wire logic        calib_select,
  input  wire logic        alarm_enable,
  input  wire logic [31:0] alarm_time,
  input  wire logic        user_time_we,
  input  wire logic [31:0] user_time_wdata,
  output logic [31:0]      user_time,
  // Shared open-drain output
  output logic             alarm_cal_wave_output_out,
  output logic             alarm_cal_wave_output_oe,
  // Status
  output logic             bus_busy
);
  if (TICK_CYC < 2 || CAL_HALF_CYC < 2 || FIFO_DEPTH < 2) begin : g_param_chk
    $error("rtcm_front counts and depth must be at least 2");
  end

  // Pin synchronisers and edge history
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};  // see R20
      sda_sync_q <= {sda_sync_q[1:0], sda_in};  // see R20
    end
  end

  wire scl_s      = scl_sync_q[1];
  wire scl_p      = scl_sync_q[2];
  wire sda_s      = sda_sync_q[1];
  wire sda_p      = sda_sync_q[2];
  wire scl_rise   = scl_s && !scl_p;
  wire scl_fall   = !scl_s && scl_p;
  wire start_det  = scl_s && scl_p && sda_p && !sda_s;  // see R9
  wire stop_det   = scl_s && scl_p && !sda_p && sda_s;  // see R12

  // Byte engine
  rtcm_state_t state_q;
  rtcm_byte_t  shift_q;
  logic [3:0]  cnt_q;
  logic        sda_oe_q;
  logic        rw_q;
  logic        clk_sel_q;
  logic        push_q;
  logic        rd_next_q;
  logic        mack_q;

  rtcm_stream_if #(.W(`RTCM_FIFO_WIDTH)) fill_if ();

  wire [3:0] id_bits    = shift_q[7:4];
  wire       id_mem     = (id_bits == `RTCM_ID_MEM);    // see R5
  wire       id_clock   = (id_bits == `RTCM_ID_CLOCK);  // see R6
  wire       pad_ok     = (shift_q[3:1] == `RTCM_ADDR_PAD);
  wire       addr_match = (id_mem || id_clock) && pad_ok;  // see R4
  wire       byte_done  = (cnt_q == `RTCM_BITS_PER_BYTE);
  wire       shift_step = (state_q == RTCM_ADDR || state_q == RTCM_RX) && scl_rise && !byte_done;

  assign fill_if.valid = push_q;
  assign fill_if.data  = {clk_sel_q, shift_q};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q   <= RTCM_IDLE;
      shift_q   <= 8'h00;
      cnt_q     <= 4'h0;
      sda_oe_q  <= 1'b0;
      rw_q      <= 1'b0;
      clk_sel_q <= 1'b0;
      push_q    <= 1'b0;
      rd_next_q <= 1'b0;
      mack_q    <= 1'b0;
    end else begin
      push_q    <= 1'b0;
      rd_next_q <= 1'b0;
      if (start_det) begin
        state_q  <= RTCM_ADDR;  // see R11
        cnt_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q  <= RTCM_IDLE;  // see R14
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          RTCM_ADDR, RTCM_RX: begin
            if (scl_rise && !byte_done) begin
              shift_q <= {shift_q[6:0], sda_s};  // see R16
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && byte_done) begin
              if (state_q == RTCM_ADDR) begin
                if (addr_match) begin
                  state_q   <= RTCM_ACK_ADDR;  // see R18
                  sda_oe_q  <= 1'b1;
                  rw_q      <= shift_q[0];     // see R17
                  clk_sel_q <= id_clock;
                end else begin
                  state_q <= RTCM_IDLE;
                end
              end else if (fill_if.ready) begin
                state_q  <= RTCM_ACK_RX;  // see R18
                sda_oe_q <= 1'b1;
                push_q   <= 1'b1;
              end else begin
                state_q <= RTCM_IDLE;
              end
            end
          end
          RTCM_ACK_ADDR, RTCM_ACK_RX: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (state_q == RTCM_ACK_ADDR && rw_q) begin
                state_q   <= RTCM_TX;
                shift_q   <= rd_data;
                sda_oe_q  <= ~rd_data[7];
                rd_next_q <= 1'b1;
              end else begin
                state_q  <= RTCM_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          RTCM_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                state_q  <= RTCM_MACK;  // see R18
                sda_oe_q <= 1'b0;
                mack_q   <= 1'b0;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];  // see R16
              end
            end
          end
          RTCM_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                state_q   <= RTCM_TX;
                shift_q   <= rd_data;
                sda_oe_q  <= ~rd_data[7];
                rd_next_q <= 1'b1;
              end else begin
                state_q <= RTCM_IDLE;  // see R18
              end
            end
          end
          default: begin
            state_q  <= RTCM_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  logic [8:0] fifo_word;

  rtcm_fifo #(
    .WIDTH (`RTCM_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_if     (fill_if),
    .out_valid (rx_valid),
    .out_data  (fifo_word),
    .out_ready (rx_ready)
  );

  assign rx_data     = fifo_word[7:0];
  assign rx_is_clock = fifo_word[8];
  assign sda_out     = 1'b0;  // see R7
  assign sda_oe      = sda_oe_q;
  assign rd_next     = rd_next_q;
  assign rd_is_clock = clk_sel_q;

  logic busy_q;
  always_ff @(posedge mclk) begin
    if (!resetn) busy_q <= 1'b0;
    else busy_q <= (state_q != RTCM_IDLE);
  end
  assign bus_busy = busy_q;

  // Timekeeping
  logic [31:0] tick_cnt_q;
  logic [31:0] run_q;
  logic [31:0] user_q;
  logic        freeze_p_q;
  logic        snap_p_q;
  wire         tick       = (tick_cnt_q == 32'(TICK_CYC - 1));
  wire         freeze_end = freeze_p_q && !time_set_freeze;
  wire         snap_rise  = time_snapshot && !snap_p_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      freeze_p_q <= 1'b0;
      snap_p_q   <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      freeze_p_q <= time_set_freeze;
      snap_p_q   <= time_snapshot;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      run_q <= 32'h0000_0000;
    end else if (freeze_end) begin
      run_q <= user_q;  // see R2
    end else if (tick) begin
      run_q <= run_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      user_q <= 32'h0000_0000;
    end else if (time_set_freeze) begin
      if (user_time_we) user_q <= user_time_wdata;  // see R1
    end else if (snap_rise || (!time_snapshot && !freeze_end)) begin
      user_q <= run_q;  // see R19
    end
  end
  assign user_time = user_q;

  // Alarm or calibration wave onto the shared pin
  logic [31:0] wave_cnt_q;
  logic        wave_q;
  logic        acs_oe_q;
  wire         wave_flip = (wave_cnt_q == 32'(CAL_HALF_CYC - 1));
  wire         alarm_hit = alarm_enable && (run_q == alarm_time);
  wire         acs_oe_d  = calib_select ? ~wave_q : alarm_hit;  // see R3

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wave_cnt_q <= 32'h0000_0000;
      wave_q     <= 1'b1;
      acs_oe_q   <= 1'b0;
    end else begin
      wave_cnt_q <= wave_flip ? 32'h0000_0000 : wave_cnt_q + 32'h0000_0001;
      if (wave_flip) wave_q <= ~wave_q;
      acs_oe_q <= acs_oe_d;
    end
  end
  assign alarm_cal_wave_output_out = 1'b0;
  assign alarm_cal_wave_output_oe  = acs_oe_q;

  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence addr_byte_done_s;
    (state_q == RTCM_ADDR) && byte_done && scl_fall && !start_det && !stop_det;
  endsequence

  sequence mack_nack_s;
    (state_q == RTCM_MACK) && !mack_q && scl_fall && !start_det && !stop_det;
  endsequence

  sequence rx_byte_done_s;
    (state_q == RTCM_RX) && byte_done && scl_fall && !start_det && !stop_det;
  endsequence

  sequence tx_byte_done_s;
    (state_q == RTCM_TX) && byte_done && scl_fall && !start_det && !stop_det;
  endsequence

  sequence mack_ack_s;
    (state_q == RTCM_MACK) && mack_q && scl_fall && !start_det && !stop_det;
  endsequence

  sequence snap_held_s;
    user_q == $past(run_q) ##1 ($stable(user_q) || !time_snapshot);
  endsequence

  start_abort_a: assert property (start_det |=> state_q == RTCM_ADDR && cnt_q == 4'h0 && !sda_oe_q)  // see R11
    else $error("start did not restart address phase");
  stop_idle_a: assert property (stop_det |=> state_q == RTCM_IDLE && !sda_oe_q)  // see R14
    else $error("stop did not return to idle");
  mem_ack_a: assert property (addr_byte_done_s and (id_mem && pad_ok) |=> sda_oe_q && !clk_sel_q)  // see R5
    else $error("memory identity not acknowledged");
  clock_ack_a: assert property (addr_byte_done_s and (id_clock && pad_ok) |=> sda_oe_q && clk_sel_q)  // see R6
    else $error("clock identity not acknowledged");
  foreign_id_a: assert property (addr_byte_done_s and !addr_match |=> state_q == RTCM_IDLE && !sda_oe_q)  // see R4
    else $error("foreign address acknowledged");
  nack_end_a: assert property (mack_nack_s |=> state_q == RTCM_IDLE ##1 !sda_oe_q [*2])  // see R18
    else $error("missing acknowledge did not end read");
  oe_scl_low_a: assert property ($rose(sda_oe_q) |-> !scl_p)  // see R16
    else $error("data line driven while clock high");
  freeze_hold_a: assert property (time_set_freeze && !user_time_we |=> $stable(user_q))  // see R1
    else $error("user time changed while frozen");
  freeze_load_a: assert property (freeze_end |=> run_q == $past(user_q))  // see R2
    else $error("user time not loaded on freeze release");
  snap_take_a: assert property (snap_rise && !time_set_freeze |=> snap_held_s)  // see R19
    else $error("snapshot not captured");
  alarm_pin_a: assert property ($past(resetn) && !$past(calib_select) |-> acs_oe_q == $past(alarm_hit))  // see R3
    else $error("alarm output not following alarm logic");
  cal_wave_a: assert property (calib_select |=> acs_oe_q == !$past(wave_q))  // see R3
    else $error("calibration wave not on shared output");
  freeze_user_a: assert property (freeze_end && !snap_rise |=> $stable(user_q))  // see R2
    else $error("user time disturbed on freeze release");
  rx_push_a: assert property (rx_byte_done_s and fill_if.ready |=> push_q && sda_oe_q && state_q == RTCM_ACK_RX)  // see R18
    else $error("received byte not acknowledged");
  full_nack_a: assert property (rx_byte_done_s and !fill_if.ready |=> !push_q && !sda_oe_q && state_q == RTCM_IDLE)  // see R18
    else $error("byte acknowledged with receive buffer full");
  tx_release_a: assert property (tx_byte_done_s |=> !sda_oe_q && state_q == RTCM_MACK)  // see R18
    else $error("data line not released for acknowledge");
  mack_next_a: assert property (mack_ack_s |=> state_q == RTCM_TX && rd_next_q)  // see R18
    else $error("acknowledged read did not load next byte");
  bit_count_a: assert property (shift_step && !start_det && !stop_det |=> cnt_q == $past(cnt_q) + 4'h1)  // see R16
    else $error("bit counter did not advance on clock rise");
endmodule

// *** logic/rtcm_pkg.sv ***
package rtcm_pkg;

  typedef enum logic [2:0] {
    RTCM_IDLE,
    RTCM_ADDR,
    RTCM_ACK_ADDR,
    RTCM_RX,
    RTCM_ACK_RX,
    RTCM_TX,
    RTCM_MACK
  } rtcm_state_t;

  typedef logic [7:0] rtcm_byte_t;

endpackage

// *** logic/rtcm_stream_if.sv ***
`timescale 1ns/10ps
interface rtcm_stream_if #(
  parameter int W = 9
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** sim/rtcm_master.sv ***
`timescale 1ns/10ps
module rtcm_master (
  // Bus lines driven by the master
  output logic      scl,
  output logic      sda_m,
  // Resolved data line
  input  wire logic sda_line
);
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Master always makes the clock, device only answers
  task automatic start();
    sda_m = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // Issued only after a data line release by the device
  task automatic stop();
    sda_m = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b1;
    #Q;
  endtask

  // Data set while clock low, sampled mid high
  task automatic bit_x(input logic b, output logic s);
    sda_m = b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~ack, s);
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
  logic        mclk;
  logic        resetn;
  logic        scl;
  logic        sda_m;
  wire         sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_is_clock;
  logic        rx_ready;
  logic [7:0]  rd_data;
  logic        rd_next;
  logic        rd_is_clock;
  logic        freeze;
  logic        snap;
  logic        calib;
  logic        alarm_en;
  logic [31:0] alarm_time;
  logic        ut_we;
  logic [31:0] ut_wdata;
  logic [31:0] user_time;
  logic        acs_out;
  logic        acs_oe;
  logic        bus_busy;
  logic        s;
  logic [31:0] v;
  logic [31:0] p;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [8:0]  exp_q[$];
  logic [7:0]  rd_q[$];
  logic [7:0]  bad_ids[4] = '{8'hB0, 8'hA2, 8'hDC, 8'h50};
  localparam int CAL_HALF = 10;

  rtcm_front #(.TICK_CYC(50), .CAL_HALF_CYC(CAL_HALF), .FIFO_DEPTH(16)) DUT (
    .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_data(rx_data), .rx_is_clock(rx_is_clock),
    .rx_ready(rx_ready), .rd_data(rd_data), .rd_next(rd_next), .rd_is_clock(rd_is_clock),
    .time_set_freeze(freeze), .time_snapshot(snap), .calib_select(calib),
    .alarm_enable(alarm_en), .alarm_time(alarm_time), .user_time_we(ut_we),
    .user_time_wdata(ut_wdata), .user_time(user_time), .alarm_cal_wave_output_out(acs_out),
    .alarm_cal_wave_output_oe(acs_oe), .bus_busy(bus_busy));

  rtcm_master master (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));

  // Pulled-up wire
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Read data source: remember each byte taken
  always @(posedge mclk) begin
    if (rd_next === 1'b1) begin
      rd_q.push_back(rd_data);
      rd_data <= 8'($urandom);
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input int n);
    logic       a;
    logic       live;
    logic [7:0] d;
    master.start();
    live = (addr[7:4] == 4'hA || addr[7:4] == 4'hD) && addr[3:1] == 3'b000;
    master.wbyte(addr, a);
    chk("addr_ack", live, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      live = live && exp_q.size() < 16;
      master.wbyte(d, a);
      chk("data_ack", live, a);
      if (live) exp_q.push_back({addr[7:4] == 4'hD, d});
    end
    master.stop();
  endtask

  task automatic rd(input logic [7:0] addr, input int n);
    logic       a;
    logic [7:0] d;
    master.start();
    master.wbyte(addr, a);
    chk("raddr_ack", 1, a);
    chk("rd_slave", addr[7:4] == 4'hD, rd_is_clock);
    for (int i = 0; i < n; i++) begin
      master.rbyte(i < n - 1, d);
      chk("rd_byte", rd_q.pop_front(), d);
    end
    master.stop();
  endtask

  task automatic drain();
    @(posedge mclk);
    rx_ready <= 1'b1;
    for (int n = 0; n < 100 && exp_q.size() > 0; n++) begin
      @(posedge mclk);
      if (rx_valid === 1'b1) chk("rx_byte", exp_q.pop_front(), {rx_is_clock, rx_data});
    end
    rx_ready <= 1'b0;
    @(posedge mclk);
    chk("rx_empty", 0, rx_valid);
    chk("rx_count", 0, exp_q.size());
  endtask

  initial begin
    resetn = 1'b0;
    rx_ready = 1'b0;
    freeze = 1'b0;
    snap = 1'b0;
    calib = 1'b0;
    alarm_en = 1'b0;
    alarm_time = 32'h0000_0000;
    ut_we = 1'b0;
    ut_wdata = 32'h0000_0000;
    rd_data = 8'h00;
    void'($urandom(29408));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk("reset_out", 0, {sda_oe, rx_valid, bus_busy, rd_next, acs_oe});
    chk("reset_time", 0, user_time);
    chk("od_levels", 0, {sda_out, acs_out});
    repeat (3) @(posedge mclk);
    wr(8'hA0, 3);
    wr(8'hD0, 2);
    drain();
    foreach (bad_ids[i]) wr(bad_ids[i], 1);
    rd(8'hA1, 3);
    rd(8'hD1, 1);
    master.start();
    repeat (4) master.bit_x(1'b1, s);
    wr(8'hD0, 1);
    drain();
    master.start();
    master.wbyte(8'hA0, s);
    repeat (3) master.bit_x(1'b0, s);
    master.stop();
    repeat (5) @(posedge mclk);
    chk("busy_after_stop", 0, bus_busy);
    chk("no_push", 0, rx_valid);
    wr(8'hA0, 17);
    drain();
    v = {8'h00, 24'($urandom)};
    @(posedge mclk);
    freeze <= 1'b1;
    ut_we <= 1'b1;
    ut_wdata <= v;
    @(posedge mclk);
    ut_we <= 1'b0;
    repeat (120) @(posedge mclk);
    chk("frozen", v, user_time);
    freeze <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("time_load", 1, user_time - v <= 1);
    p = user_time;
    snap <= 1'b1;
    repeat (2) @(posedge mclk);
    v = user_time;
    chk("snap_take", 1, v - p <= 1);
    repeat (120) @(posedge mclk);
    chk("snap_hold", v, user_time);
    snap <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("run_count", 1, user_time - v >= 2 && user_time - v <= 3);
    alarm_en <= 1'b1;
    alarm_time <= user_time + 2;
    for (int n = 0; n < 300 && acs_oe !== 1'b1; n++) @(posedge mclk);
    chk("alarm_pin", 1, acs_oe);
    chk("alarm_match", alarm_time, user_time);
    calib <= 1'b1;
    repeat (20) @(posedge mclk);
    p[0] = acs_oe;
    v = 32'h0000_0000;
    repeat (100) begin
      @(posedge mclk);
      if (acs_oe !== p[0]) v = v + 32'h0000_0001;
      p[0] = acs_oe;
    end
    chk("cal_toggles", 100 / CAL_HALF, v);
    stop_test();
  end
endmodule
